// File: rtl/disk_adapter_pkg.sv
// Constants and types shared by the disk channel adapter datapath
package disk_adapter_pkg;
  // Head-parallel slice: eight data heads plus one parity head
  localparam int          SLICE_W     = 9;
  localparam int          DATA_W      = 64;
  localparam int          DRIVES      = 8;
  // Hamming codeword length used by the word check byte
  localparam int          CODE_BITS   = 72;
  // Logical sector and cylinder limits
  localparam logic [4:0]  SECTOR_CNT  = 5'h17;
  localparam logic [11:0] CYL_CNT     = 12'hA30;
  // Words per block and slices per sector (nine slices per word)
  localparam logic [11:0] WORD_CNT    = 12'h800;
  localparam logic [14:0] SECTOR_SLC  = 15'h4800;
  // Slot of the check byte inside a word's nine slices
  localparam logic [3:0]  CHK_SLOT    = 4'h8;
  // Length of the repeated field over a media flaw, in slices
  localparam logic [4:0]  COPY_LEN    = 5'h12;
  localparam logic [7:0]  DRV_ONE     = 8'h01;

  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    WRITE = 2'b01,
    READ  = 2'b10
  } state_t;
endpackage

// File: rtl/disk_adapter.sv
// Disk channel adapter datapath: drive select, slicing, ECC, flaw skip
`timescale 1ns/1ps
`default_nettype none
module disk_adapter (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  cmdValid,
  input  wire logic                                  cmdWrite,
  input  wire logic [2:0]                            cmdDrive,
  input  wire logic [11:0]                           cmdCyl,
  input  wire logic [4:0]                            cmdSector,
  input  wire logic                                  cmdHeadSet,
  output logic                                       cmdReject,
  output logic                                       busy,
  output logic                                       done,
  input  wire logic [disk_adapter_pkg::DATA_W-1:0]   bufWrData,
  input  wire logic                                  bufWrValid,
  output logic                                       bufWrReady,
  output logic      [disk_adapter_pkg::DATA_W-1:0]   bufRdData,
  output logic                                       bufRdValid,
  output logic                                       eccFixed,
  output logic                                       eccFailed,
  output logic                                       parityErr,
  output logic      [disk_adapter_pkg::DRIVES-1:0]   driveSel,
  output logic                                       ctlWrite,
  output logic      [11:0]                           ctlCyl,
  output logic      [4:0]                            ctlSector,
  output logic                                       ctlHeadSet,
  output logic                                       ctlStrobe,
  input  wire logic [7:0]                            statusIn,
  output logic      [7:0]                            statusOut,
  input  wire logic [14:0]                           idDefect,
  input  wire logic                                  idFlawed,
  output logic      [disk_adapter_pkg::SLICE_W-1:0]  wrSlice,
  output logic                                       wrStrobe,
  input  wire logic [disk_adapter_pkg::SLICE_W-1:0]  rdSlice,
  input  wire logic                                  rdToggle
);
  import disk_adapter_pkg::*;

  typedef struct packed {
    state_t                          state;
    logic [SLICE_W-1:0]              rdS1;
    logic [SLICE_W-1:0]              rdS2;
    logic                            tgS1;
    logic                            tgS2;
    logic                            tgS3;
    logic [7:0]                      stS1;
    logic [7:0]                      stS2;
    logic [14:0]                     idS1;
    logic [14:0]                     idS2;
    logic                            flS1;
    logic                            flS2;
    logic [14:0]                     defect;
    logic                            flawed;
    logic                            flawDone;
    logic [14:0]                     cnt;
    logic [11:0]                     words;
    logic [3:0]                      slot;
    logic [DATA_W-1:0]               wordBuf;
    logic                            haveWord;
    logic [COPY_LEN-1:0][SLICE_W-1:0] hist;
    logic                            replay;
    logic [4:0]                      rep;
    logic [4:0]                      dis;
    logic [7:0]                      rdChk;
    logic                            wrRdy;
    logic [SLICE_W-1:0]              wrSlice;
    logic                            wrStrobe;
    logic [DATA_W-1:0]               rdData;
    logic                            rdValid;
    logic                            eccFix;
    logic                            eccBad;
    logic                            parErr;
    logic [DRIVES-1:0]               driveSel;
    logic [11:0]                     ctlCyl;
    logic [4:0]                      ctlSector;
    logic                            ctlHeadSet;
    logic                            ctlWrite;
    logic                            ctlStrobe;
    logic [7:0]                      statusOut;
    logic                            busy;
    logic                            done;
    logic                            cmdReject;
  } adapter_t;

  adapter_t st_r;
  adapter_t st_nxt;

  // Hamming check byte: low seven bits are the XOR of the codeword
  // positions of all set data bits, bit 7 is overall parity
  function automatic logic [7:0] eccCode(input logic [DATA_W-1:0] d);
    int         k;
    logic [6:0] c;
    k = 0;
    c = '0;
    for (int p = 1; p < CODE_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) begin
          c = c ^ 7'(p);
        end
        k++;
      end
    end
    return {^{d, c}, c};
  endfunction

  // Data bit mask for a syndrome; check-bit positions give no mask
  function automatic logic [DATA_W-1:0] fixMask(input logic [6:0] syn);
    int                k;
    logic [DATA_W-1:0] m;
    k = 0;
    m = '0;
    for (int p = 1; p < CODE_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (7'(p) == syn) begin
          m[k] = 1'b1;
        end
        k++;
      end
    end
    return m;
  endfunction

  logic              newSlice;
  logic              copyNow;
  logic              dropNow;
  logic [7:0]        outByte;
  logic [7:0]        inByte;
  logic [7:0]        wordChk;
  logic [6:0]        syn;
  logic              odd;

  // A new read slice is one change of the synchronised toggle
  assign newSlice = st_r.tgS2 ^ st_r.tgS3;
  assign copyNow  = st_r.flawed && !st_r.flawDone &&
                    (st_r.cnt == st_r.defect) && st_r.haveWord;
  assign dropNow  = st_r.flawed && !st_r.flawDone &&
                    (st_r.cnt == st_r.defect);
  assign wordChk  = eccCode(st_r.wordBuf);
  assign outByte  = (st_r.slot == CHK_SLOT) ? wordChk :
                    st_r.wordBuf[st_r.slot[2:0]*8 +: 8];
  assign inByte   = st_r.rdS2[7:0];
  assign syn      = wordChk[6:0] ^ inByte[6:0];
  assign odd      = (^st_r.wordBuf) ^ (^inByte);

  // Next-state logic for the whole adapter
  always_comb begin
    st_nxt = st_r;
    // Drive-side pin inputs pass two flops before use
    st_nxt.rdS1      = rdSlice;
    st_nxt.rdS2      = st_r.rdS1;
    st_nxt.tgS1      = rdToggle;
    st_nxt.tgS2      = st_r.tgS1;
    st_nxt.tgS3      = st_r.tgS2;
    st_nxt.stS1      = statusIn;
    st_nxt.stS2      = st_r.stS1;
    st_nxt.idS1      = idDefect;
    st_nxt.idS2      = st_r.idS1;
    st_nxt.flS1      = idFlawed;
    st_nxt.flS2      = st_r.flS1;
    st_nxt.statusOut = st_r.stS2;
    st_nxt.ctlStrobe = 1'b0;
    st_nxt.wrStrobe  = 1'b0;
    st_nxt.rdValid   = 1'b0;
    st_nxt.eccFix    = 1'b0;
    st_nxt.eccBad    = 1'b0;
    st_nxt.parErr    = 1'b0;
    st_nxt.done      = 1'b0;
    st_nxt.cmdReject = 1'b0;
    st_nxt.replay    = 1'b0;
    unique case (st_r.state)
      IDLE: begin
        // Out-of-range sector or cylinder is refused, nothing moves
        if (cmdValid) begin
          if (cmdSector < SECTOR_CNT && cmdCyl < CYL_CNT) begin
            st_nxt.state      = cmdWrite ? WRITE : READ;
            st_nxt.driveSel   = DRV_ONE << cmdDrive;
            st_nxt.ctlCyl     = cmdCyl;
            st_nxt.ctlSector  = cmdSector;
            st_nxt.ctlHeadSet = cmdHeadSet;
            st_nxt.ctlWrite   = cmdWrite;
            st_nxt.ctlStrobe  = 1'b1;
            st_nxt.defect     = st_r.idS2;
            st_nxt.flawed     = st_r.flS2;
            st_nxt.flawDone   = 1'b0;
            st_nxt.cnt        = '0;
            st_nxt.words      = '0;
            st_nxt.slot       = '0;
            st_nxt.haveWord   = 1'b0;
            st_nxt.rep        = '0;
            st_nxt.dis        = '0;
            st_nxt.busy       = 1'b1;
          end else begin
            st_nxt.cmdReject = 1'b1;
          end
        end
      end
      WRITE: begin
        if (copyNow) begin
          // Oldest remembered slice first, count not advanced
          st_nxt.wrSlice  = st_r.hist[COPY_LEN - 5'h01 - st_r.rep];
          st_nxt.wrStrobe = 1'b1;
          st_nxt.replay   = 1'b1;
          st_nxt.rep      = st_r.rep + 5'h01;
          if (st_r.rep == COPY_LEN - 5'h01) begin
            st_nxt.flawDone = 1'b1;
          end
        end else if (st_r.haveWord) begin
          st_nxt.wrSlice  = {~^outByte, outByte};
          st_nxt.wrStrobe = 1'b1;
          st_nxt.hist     = {st_r.hist[COPY_LEN-2:0],
                             {~^outByte, outByte}};
          st_nxt.cnt      = st_r.cnt + 15'h0001;
          if (st_r.slot == CHK_SLOT) begin
            st_nxt.slot     = '0;
            st_nxt.haveWord = 1'b0;
          end else begin
            st_nxt.slot = st_r.slot + 4'h1;
          end
        end else if (st_r.wrRdy && bufWrValid) begin
          st_nxt.wordBuf  = bufWrData;
          st_nxt.haveWord = 1'b1;
          st_nxt.words    = st_r.words + 12'h001;
        end
        if (!st_r.haveWord && st_r.cnt == SECTOR_SLC) begin
          st_nxt.state    = IDLE;
          st_nxt.done     = 1'b1;
          st_nxt.busy     = 1'b0;
          st_nxt.driveSel = '0;
        end
      end
      READ: begin
        if (newSlice && dropNow) begin
          // Repeated field over the flaw never reaches the buffer
          st_nxt.dis     = st_r.dis + 5'h01;
          if (st_r.dis == COPY_LEN - 5'h01) begin
            st_nxt.flawDone = 1'b1;
          end
        end else if (newSlice) begin
          st_nxt.parErr  = ~^st_r.rdS2;
          st_nxt.cnt     = st_r.cnt + 15'h0001;
          if (st_r.slot == CHK_SLOT) begin
            st_nxt.slot    = '0;
            st_nxt.rdChk   = inByte;
            st_nxt.rdValid = 1'b1;
            st_nxt.words   = st_r.words + 12'h001;
            st_nxt.rdData  = st_r.wordBuf;
            if (odd) begin
              // Single error: flip it; a check-bit hit gives no mask
              st_nxt.rdData = st_r.wordBuf ^ fixMask(syn);
              st_nxt.eccFix = 1'b1;
            end else if (syn != '0) begin
              st_nxt.eccBad = 1'b1;
            end
          end else begin
            st_nxt.wordBuf[st_r.slot[2:0]*8 +: 8] = inByte;
            st_nxt.slot = st_r.slot + 4'h1;
          end
        end
        if (st_r.cnt == SECTOR_SLC) begin
          st_nxt.state    = IDLE;
          st_nxt.done     = 1'b1;
          st_nxt.busy     = 1'b0;
          st_nxt.driveSel = '0;
        end
      end
      default: begin
        st_nxt.state = IDLE;
      end
    endcase
    // Buffer word taken only when the previous one is fully sent
    st_nxt.wrRdy = (st_nxt.state == WRITE) && !st_nxt.haveWord &&
                   (st_nxt.words != WORD_CNT);
  end

  // Single state register for the whole block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmdReject  = st_r.cmdReject;
  assign busy       = st_r.busy;
  assign done       = st_r.done;
  assign bufWrReady = st_r.wrRdy;
  assign bufRdData  = st_r.rdData;
  assign bufRdValid = st_r.rdValid;
  assign eccFixed   = st_r.eccFix;
  assign eccFailed  = st_r.eccBad;
  assign parityErr  = st_r.parErr;
  assign driveSel   = st_r.driveSel;
  assign ctlWrite   = st_r.ctlWrite;
  assign ctlCyl     = st_r.ctlCyl;
  assign ctlSector  = st_r.ctlSector;
  assign ctlHeadSet = st_r.ctlHeadSet;
  assign ctlStrobe  = st_r.ctlStrobe;
  assign statusOut  = st_r.statusOut;
  assign wrSlice    = st_r.wrSlice;
  assign wrStrobe   = st_r.wrStrobe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence copyStart;
    !st_r.replay ##1 st_r.replay;
  endsequence

  sequence copyEnd;
    st_r.replay && st_r.rep == COPY_LEN ##1 !st_r.replay;
  endsequence

  one_drive_a: assert property (
    $onehot0(driveSel) && (busy || driveSel == '0))
    else $error("more than one drive selected");

  slice_parity_a: assert property (
    wrStrobe |-> ^wrSlice)
    else $error("write slice parity not odd");

  cmd_range_a: assert property (
    ctlStrobe |-> ctlSector < SECTOR_CNT && ctlCyl < CYL_CNT)
    else $error("command out of range accepted");

  block_len_a: assert property (
    done |-> $past(st_r.words) == WORD_CNT)
    else $error("block not 2048 words");

  copy_run_a: assert property (
    copyStart |-> ##17 copyEnd)
    else $error("flaw copy field not 18 slices");

  copy_count_a: assert property (
    st_r.replay |-> wrStrobe && st_r.cnt == st_r.defect)
    else $error("copy slice advanced the count");

  drop_field_a: assert property (
    $rose(st_r.flawDone) && st_r.state == READ |->
      st_r.dis == COPY_LEN && st_r.cnt == st_r.defect)
    else $error("flaw field drop wrong");

  ecc_gen_a: assert property (
    wrStrobe && !st_r.replay && $past(st_r.slot) == CHK_SLOT |->
      wrSlice[7:0] == eccCode(st_r.wordBuf))
    else $error("write check byte wrong");

  ecc_clean_a: assert property (
    bufRdValid && !eccFixed && !eccFailed |->
      eccCode(bufRdData) == st_r.rdChk)
    else $error("clean read word fails its check");

endmodule
`default_nettype wire

// File: verif/disk_drive_model.sv
// Behavioural model of the chained drives facing the adapter
`timescale 1ns/1ps
`default_nettype none
module disk_drive_model (
  input  wire logic                                  clk,
  input  wire logic [disk_adapter_pkg::DRIVES-1:0]   driveSel,
  input  wire logic [disk_adapter_pkg::SLICE_W-1:0]  wrSlice,
  input  wire logic                                  wrStrobe,
  output logic      [7:0]                            statusIn,
  output logic      [14:0]                           idDefect,
  output logic                                       idFlawed,
  output logic      [disk_adapter_pkg::SLICE_W-1:0]  rdSlice,
  output logic                                       rdToggle
);
  import disk_adapter_pkg::*;

  logic [SLICE_W-1:0] wrQ[$];

  // Each drive reports its own bit while selected, so a clash would show;
  // only this adapter's chain is modelled, the other port stays unused
  assign statusIn = driveSel;

  initial begin
    idDefect = 15'h0000;
    idFlawed = 1'b0;
    rdSlice  = 9'h000;
    rdToggle = 1'b0;
  end

  // Record every slice laid on the surface, flaw copies included
  always @(posedge clk) begin
    if (wrStrobe) wrQ.push_back(wrSlice);
  end

  // Sector ID defect parameter as read from the surface
  task automatic set_flaw(input logic f, input logic [14:0] d);
    idFlawed = f;
    idDefect = d;
  endtask

  // One slice per toggle, held 4 clk either side; afterwards the line is
  // inverted so that a stale value can never pass for fresh data
  task automatic send(input logic [SLICE_W-1:0] s);
    @(posedge clk) #1 rdSlice = s;
    repeat (4) @(posedge clk);
    #1 rdToggle = ~rdToggle;
    repeat (4) @(posedge clk);
    #1 rdSlice = ~s;
  endtask
endmodule
`default_nettype wire

// File: verif/disk_adapter_test.sv
// Self-checking bench for the disk channel adapter datapath
`timescale 1ns/1ps
`default_nettype none
module disk_adapter_test;
  import disk_adapter_pkg::*;
  logic              clk, sys_rst, cmdValid, cmdWrite, cmdHeadSet;
  logic [2:0]        cmdDrive;
  logic [11:0]       cmdCyl, ctlCyl;
  logic [4:0]        cmdSector, ctlSector;
  logic              cmdReject, busy, done, bufWrValid, bufWrReady;
  logic [63:0]       bufWrData, bufRdData;
  logic              bufRdValid, eccFixed, eccFailed, parityErr;
  logic [7:0]        driveSel, statusIn, statusOut;
  logic              ctlWrite, ctlHeadSet, ctlStrobe, idFlawed;
  logic [14:0]       idDefect;
  logic [8:0]        wrSlice, rdSlice;
  logic              wrStrobe, rdToggle;
  int                miscompares, cmp_count, cycles;
  int                strobeCnt, rejCnt, doneCnt, perrCnt;
  logic [65:0]       rdQ[$];
  logic [8:0]        v[$];

  disk_adapter i_disk_adapter (.clk(clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdDrive(cmdDrive),
    .cmdCyl(cmdCyl), .cmdSector(cmdSector), .cmdHeadSet(cmdHeadSet),
    .cmdReject(cmdReject), .busy(busy), .done(done),
    .bufWrData(bufWrData), .bufWrValid(bufWrValid),
    .bufWrReady(bufWrReady), .bufRdData(bufRdData),
    .bufRdValid(bufRdValid), .eccFixed(eccFixed), .eccFailed(eccFailed),
    .parityErr(parityErr), .driveSel(driveSel), .ctlWrite(ctlWrite),
    .ctlCyl(ctlCyl), .ctlSector(ctlSector), .ctlHeadSet(ctlHeadSet),
    .ctlStrobe(ctlStrobe), .statusIn(statusIn), .statusOut(statusOut),
    .idDefect(idDefect), .idFlawed(idFlawed), .wrSlice(wrSlice),
    .wrStrobe(wrStrobe), .rdSlice(rdSlice), .rdToggle(rdToggle));

  disk_drive_model i_disk_drive_model (.clk(clk), .driveSel(driveSel),
    .wrSlice(wrSlice), .wrStrobe(wrStrobe), .statusIn(statusIn),
    .idDefect(idDefect), .idFlawed(idFlawed), .rdSlice(rdSlice),
    .rdToggle(rdToggle));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Distinct word per index so misordered bytes or words show up
  function automatic logic [63:0] word(input int i);
    return {16'hC35A ^ i[15:0], ~i[15:0], i[15:0], 16'h5AA5};
  endfunction

  task automatic check(input string name, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Pulses are counted on the edge where they stand; hang guard too
  always @(posedge clk) begin
    cycles++;
    if (ctlStrobe) strobeCnt++;
    if (cmdReject) rejCnt++;
    if (done) doneCnt++;
    if (parityErr) perrCnt++;
    if (bufRdValid) rdQ.push_back({eccFixed, eccFailed, bufRdData});
    check("driveSel onehot", 1, $onehot0(driveSel));
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  // Command held one edge, then two cycles for the registered answer
  task automatic cmd(input logic w, input logic [2:0] d,
                     input logic [11:0] c, input logic [4:0] s,
                     input logic h);
    @(posedge clk) #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdDrive = d;
    cmdCyl = c;
    cmdSector = s;
    cmdHeadSet = h;
    @(posedge clk) #1;
    cmdValid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_reject();
    cmd(1'b0, 3'h3, 12'h000, 5'h17, 1'b0);
    check("reject sector", 1, rejCnt);
    cmd(1'b0, 3'h3, 12'hA30, 5'h00, 1'b0);
    check("reject cylinder", 2, rejCnt);
    check("busy after reject", 0, busy);
    check("strobe after reject", 0, strobeCnt);
    $display("test reject finished");
  endtask

  // Last cylinder and sector, flaw at slice 20, whole block of words
  task automatic test_write();
    int k;
    logic [63:0] w;
    logic [8:0] q[$];
    i_disk_drive_model.set_flaw(1'b1, 15'h0014);
    repeat (4) @(posedge clk);
    cmd(1'b1, 3'h5, 12'hA2F, 5'h16, 1'b1);
    check("write select", 8'h20, driveSel);
    check("write control", {1'b1, 12'hA2F, 5'h16, 1'b1},
          {ctlWrite, ctlCyl, ctlSector, ctlHeadSet});
    check("write strobe count", 1, strobeCnt);
    for (int i = 0; i < 2048; i++) begin
      bufWrData = word(i);
      bufWrValid = 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (!bufWrReady && k < 30);
      #1;
      if (i == 4) check("status back", 8'h20, statusOut);
    end
    bufWrValid = 1'b0;
    k = 0;
    while (doneCnt == 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    #1;
    check("done count", 1, doneCnt);
    check("idle after done", 0, {busy, driveSel});
    q = i_disk_drive_model.wrQ;
    check("slice count", 18450, q.size());
    foreach (q[j]) check("odd parity", 1, ^q[j]);
    for (int j = 0; j < 18; j++) check("flaw copy", q[j + 2], q[j + 20]);
    foreach (q[j]) if (j < 20 || j > 37) v.push_back(q[j]);
    for (int i = 0; i < 2048; i++) begin
      w = word(i);
      for (int j = 0; j < 8; j++) check("data byte", w[8*j +: 8], v[9*i+j][7:0]);
    end
    $display("test write finished");
  endtask

  // Flaw at slice 9 with 18 bad-parity copies; single, double and
  // parity faults in words 1..3; then reset aborts the sector
  task automatic test_read();
    int j;
    logic [8:0] s;
    i_disk_drive_model.set_flaw(1'b1, 15'h0009);
    repeat (4) @(posedge clk);
    cmd(1'b0, 3'h2, 12'h000, 5'h00, 1'b0);
    check("read select", {8'h04, 2'b00}, {driveSel, ctlWrite, ctlHeadSet});
    check("read strobe count", 2, strobeCnt);
    for (int k = 0; k < 54; k++) begin
      j = (k < 9) ? k : k - 18;
      s = (k >= 9 && k < 27) ? 9'h0AA : v[j];
      if (k == 28) s = s ^ 9'h101;
      if (k == 38) s = s ^ 9'h003;
      if (k == 48) s = s ^ 9'h100;
      i_disk_drive_model.send(s);
    end
    repeat (8) @(posedge clk);
    #1;
    check("read words", 4, rdQ.size());
    check("word0", word(0), rdQ[0][63:0]);
    check("word0 flags", 0, rdQ[0][65:64]);
    check("word1 fixed", word(1), rdQ[1][63:0]);
    check("word1 flags", 2'b10, rdQ[1][65:64]);
    check("word2 flags", 2'b01, rdQ[2][65:64]);
    check("word3", word(3), rdQ[3][63:0]);
    check("word3 flags", 0, rdQ[3][65:64]);
    check("parity errors", 1, perrCnt);
    check("busy mid sector", 1, busy);
    sys_rst = 1'b1;
    #1;
    check("abort idle", 0, {busy, driveSel, bufRdValid});
    @(posedge clk) #1;
    sys_rst = 1'b0;
    $display("test read finished");
  endtask

  initial begin
    sys_rst = 1'b1;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdDrive = 3'h0;
    cmdCyl = 12'h000;
    cmdSector = 5'h00;
    cmdHeadSet = 1'b0;
    bufWrData = 64'h0;
    bufWrValid = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    test_reject();
    test_write();
    test_read();
    final_report();
  end
endmodule
`default_nettype wire
